/* File: tsimm_conn_mem.sv */
`timescale 1ns/1ps
module tsimm_conn_mem (
  // clock
  input  wire logic                         clk,
  // write port
  input  wire logic                         wr_en,
  input  wire logic                         wr_all,
  input  wire tsimm_pkg::tsimm_slot_type    wr_slot,
  input  wire tsimm_pkg::tsimm_cm_word_type wr_word,
  // read ports
  input  wire tsimm_pkg::tsimm_slot_type    rd_tx_slot,
  output tsimm_pkg::tsimm_cm_word_type      rd_tx_word,
  input  wire tsimm_pkg::tsimm_slot_type    rd_rx_slot,
  output tsimm_pkg::tsimm_cm_word_type      rd_rx_word,
  input  wire tsimm_pkg::tsimm_slot_type    rd_cpu_slot,
  output tsimm_pkg::tsimm_cm_word_type      rd_cpu_word
);

  logic [15:0] mem_q [0:511];

  // storage has no reset; contents undefined until written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      if (wr_all) begin
        for (int s = 0; s < 4; s++) begin
          mem_q[{s[1:0], wr_slot.channel}] <= wr_word; // all streams at once
        end
      end else begin
        mem_q[tsimm_pkg::slot_index(wr_slot)] <= wr_word;
      end
    end
  end

  // asynchronous reads by index
  assign rd_tx_word  = mem_q[tsimm_pkg::slot_index(rd_tx_slot)];
  assign rd_rx_word  = mem_q[tsimm_pkg::slot_index(rd_rx_slot)];
  assign rd_cpu_word = mem_q[tsimm_pkg::slot_index(rd_cpu_slot)];

endmodule : tsimm_conn_mem

/* File: tsimm_data_mem.sv */
`timescale 1ns/1ps
module tsimm_data_mem (
  // clock
  input  wire logic                      clk,
  // receive write port
  input  wire logic                      rx_we,
  input  wire tsimm_pkg::tsimm_slot_type rx_slot,
  input  wire logic [7:0]                rx_data,
  // loopback write port, wins on the same location
  input  wire logic                      lb_we,
  input  wire tsimm_pkg::tsimm_slot_type lb_slot,
  input  wire logic [7:0]                lb_data,
  // read ports
  input  wire tsimm_pkg::tsimm_slot_type rd_src_slot,
  output logic [7:0]                     rd_src_data,
  input  wire tsimm_pkg::tsimm_slot_type rd_cpu_slot,
  output logic [7:0]                     rd_cpu_data
);

  logic [7:0] mem_q [0:511];

  // serial side writes only; processor never writes here
  always_ff @(posedge clk) begin
    if (rx_we) begin
      mem_q[tsimm_pkg::slot_index(rx_slot)] <= rx_data;
    end
    if (lb_we) begin
      mem_q[tsimm_pkg::slot_index(lb_slot)] <= lb_data;
    end
  end

  // asynchronous reads by index
  assign rd_src_data = mem_q[tsimm_pkg::slot_index(rd_src_slot)];
  assign rd_cpu_data = mem_q[tsimm_pkg::slot_index(rd_cpu_slot)];

endmodule : tsimm_data_mem

/* File: tsimm_host.sv */
`timescale 1ns/1ps
module tsimm_host (
  // clock
  input  wire logic        clk,
  // request from bench
  input  wire logic        req,
  input  wire logic        rw,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  // microport
  output logic             mp_cs_n,
  output logic             mp_ds,
  output logic             mp_rw,
  output logic [7:0]       mp_addr,
  output logic [15:0]      mp_data_in,
  input  wire logic [15:0] mp_data_out,
  input  wire logic        mp_dta_n
);
  initial begin
    mp_cs_n    = 1'b1;
    mp_ds      = 1'b0;
    mp_rw      = 1'b1;
    mp_addr    = 8'h00;
    mp_data_in = 16'h0000;
    done       = 1'b0;
    rdata      = 16'h0000;
  end
  // hold strobe until ack sampled, then release and scramble bus
  always @(posedge clk) begin
    done <= 1'b0;
    if (mp_ds && mp_dta_n === 1'b0) begin
      rdata      <= mp_data_out;
      done       <= 1'b1;
      mp_cs_n    <= 1'b1;
      mp_ds      <= 1'b0;
      mp_addr    <= ~mp_addr;
      mp_data_in <= ~mp_data_in;
    end else if (req && !mp_ds) begin
      mp_cs_n    <= 1'b0;
      mp_ds      <= 1'b1;
      mp_rw      <= rw;
      mp_addr    <= addr;
      mp_data_in <= wdata;
    end
  end
endmodule : tsimm_host

/* File: tsimm_pkg.sv */
package tsimm_pkg;

  // register selects on the low seven address bits when the high bit is low
  localparam logic [6:0] REG_SWITCH_CONTROL = 7'h00;
  localparam logic [6:0] REG_INTERFACE_MODE = 7'h01;
  localparam logic [6:0] REG_FRAME_ALIGN    = 7'h02;
  localparam logic [6:0] REG_FRAME_OFFSET   = 7'h03;

  // switch_control fields
  localparam int CTL_STREAM_LSB     = 0;
  localparam int CTL_MEMSEL_BIT     = 4;
  localparam int CTL_FILL_ALLOW_BIT = 5;
  localparam logic [15:0] CTL_WMASK = 16'h0033;

  // interface_mode_reg fields
  localparam int IMS_GO_BIT      = 0;
  localparam int IMS_STANDBY_BIT = 1;
  localparam int IMS_EVAL_BIT    = 2;
  localparam int IMS_PATTERN_LSB = 5;
  localparam logic [15:0] IMS_WMASK = 16'h03E7;

  // values after reset
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] IMS_RESET = 16'h0000;
  localparam logic [15:0] FOR_RESET = 16'h0000;

  // channel space and block fill sweep
  localparam logic [6:0] FILL_LAST   = 7'h7F;
  localparam logic [8:0] FRAME_SLOTS = 9'h080;
  localparam logic [8:0] NEAR_SPAN   = 9'h002;

  // microport handshake states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACK  = 3'h2,
    ST_HOLD = 3'h4
  } tsimm_state_type;

  // one stream / channel location
  typedef struct packed {
    logic [1:0] stream;
    logic [6:0] channel;
  } tsimm_slot_type;

  // connection memory word; fill pattern lands on bits 15..11
  typedef struct packed {
    logic       spare;
    logic       processor_mode_bit;
    logic       output_enable;
    logic       delay_const;
    logic       channel_loopback;
    logic [1:0] reserved;
    logic [1:0] source_stream_field;
    logic [6:0] source_channel_field;
  } tsimm_cm_word_type;

  // per time slot result handed to the serial section
  typedef struct packed {
    logic [7:0] data;
    logic       drive;
    logic       delay_const;
    logic       channel_loopback;
    logic [8:0] delay_slots;
  } tsimm_tx_type;

  // flat memory index of a location
  function automatic logic [8:0] slot_index(tsimm_slot_type s);
    return {s.stream, s.channel};
  endfunction : slot_index

  // throughput delay in time slots from input n to output m
  function automatic logic [8:0] delay_slots(logic [6:0] n, logic [6:0] m,
                                             logic cnst);
    logic [8:0] nn;
    logic [8:0] mm;
    nn = {2'h0, n};
    mm = {2'h0, m};
    if (cnst) return FRAME_SLOTS + (FRAME_SLOTS - nn) + mm;
    else if (mm < nn) return FRAME_SLOTS - (nn - mm);
    else if (mm <= nn + NEAR_SPAN) return mm - nn + FRAME_SLOTS;
    else return mm - nn;
  endfunction : delay_slots

endpackage : tsimm_pkg

/* File: tsimm_switch.sv */
`timescale 1ns/1ps
module tsimm_switch (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // microport
  input  wire logic                      mp_cs_n,
  input  wire logic                      mp_ds,
  input  wire logic                      mp_rw,
  input  wire logic [7:0]                mp_addr,
  input  wire logic [15:0]               mp_data_in,
  output logic [15:0]                    mp_data_out,
  output logic                           mp_data_oe,
  output logic                           mp_dta_n,
  // output drive pin
  input  wire logic                      global_drive_pin,
  // frame section
  input  wire logic [15:0]               frame_align_in,
  output logic [15:0]                    frame_offset_out,
  output logic                           frame_eval_start,
  // receive slots
  input  wire logic                      rx_valid,
  input  wire tsimm_pkg::tsimm_slot_type rx_slot,
  input  wire logic [7:0]                rx_data,
  // transmit slots
  input  wire logic                      tx_valid,
  input  wire tsimm_pkg::tsimm_slot_type tx_slot,
  output logic                           tx_out_valid,
  output tsimm_pkg::tsimm_tx_type        tx_out,
  output logic                           tx_drivers_en
);

  tsimm_pkg::tsimm_state_type    state_q, state_d;
  logic [15:0]                   ctl_q, ctl_d;
  logic [15:0]                   ims_q, ims_d;
  logic [15:0]                   for_q, for_d;
  logic [15:0]                   rdata_q, rdata_d;
  logic                          rd_q, rd_d;
  logic [6:0]                    fill_idx_q, fill_idx_d;
  logic                          drv_q, drv_d;
  logic                          txv_q, txv_d;
  tsimm_pkg::tsimm_tx_type       tx_q, tx_d;
  logic                          req;
  logic                          take;
  logic                          reg_wr;
  logic                          cpu_cm_wr;
  logic                          fill_active;
  logic                          fill_step;
  logic                          cm_we;
  logic                          cm_all;
  tsimm_pkg::tsimm_slot_type     cpu_slot;
  tsimm_pkg::tsimm_slot_type     cm_wslot;
  tsimm_pkg::tsimm_slot_type     src_slot;
  tsimm_pkg::tsimm_cm_word_type  cm_wword;
  tsimm_pkg::tsimm_cm_word_type  fill_word;
  tsimm_pkg::tsimm_cm_word_type  cm_tx;
  tsimm_pkg::tsimm_cm_word_type  cm_rx;
  tsimm_pkg::tsimm_cm_word_type  cm_cpu;
  logic [7:0]                    dm_src;
  logic [7:0]                    dm_cpu;
  logic [7:0]                    tx_byte;
  logic                          output_standby_bit;
  logic                          lb_we;

  // access decode
  assign req       = !mp_cs_n && mp_ds;
  assign take      = (state_q == tsimm_pkg::ST_IDLE) && req;
  assign reg_wr    = take && !mp_rw && !mp_addr[7];
  assign cpu_cm_wr = take && !mp_rw && mp_addr[7];
  assign cpu_slot  = '{stream:  ctl_q[tsimm_pkg::CTL_STREAM_LSB +: 2],
                       channel: mp_addr[6:0]};
  assign output_standby_bit       = ims_q[tsimm_pkg::IMS_STANDBY_BIT];

  // block fill sweep, processor writes take the port first
  assign fill_active = ims_q[tsimm_pkg::IMS_GO_BIT]
                       && ctl_q[tsimm_pkg::CTL_FILL_ALLOW_BIT];
  assign fill_step   = fill_active && !cpu_cm_wr;
  assign fill_word   = tsimm_pkg::tsimm_cm_word_type'(
                         {ims_q[tsimm_pkg::IMS_PATTERN_LSB +: 5],
                          11'h000});

  // connection memory write mux
  always_comb begin
    cm_we    = cpu_cm_wr || fill_step;
    cm_all   = !cpu_cm_wr;
    cm_wslot = cpu_cm_wr ? cpu_slot
                         : tsimm_pkg::tsimm_slot_type'{stream:  2'h0,
                                                       channel: fill_idx_q};
    cm_wword = cpu_cm_wr ? tsimm_pkg::tsimm_cm_word_type'(mp_data_in)
                         : fill_word;
  end

  // microport handshake and register state
  always_comb begin
    state_d    = state_q;
    ctl_d      = ctl_q;
    ims_d      = ims_q;
    for_d      = for_q;
    rdata_d    = rdata_q;
    rd_d       = rd_q;
    fill_idx_d = fill_active ? fill_idx_q : 7'h00;
    // hardware clears go at the end of the sweep
    if (fill_step) begin
      fill_idx_d = fill_idx_q + 7'h01;
      if (fill_idx_q == tsimm_pkg::FILL_LAST) begin
        ims_d[tsimm_pkg::IMS_GO_BIT] = 1'h0;
        fill_idx_d = 7'h00;
      end
    end
    case (state_q)
      tsimm_pkg::ST_IDLE: begin
        if (take) begin
          state_d = tsimm_pkg::ST_ACK;
          rd_d    = mp_rw;
          rdata_d = 16'h0000;
          if (mp_addr[7]) begin
            if (ctl_q[tsimm_pkg::CTL_MEMSEL_BIT]) begin
              rdata_d = {8'h00, dm_cpu};
            end else begin
              rdata_d = cm_cpu;
            end
          end else begin
            case (mp_addr[6:0])
              tsimm_pkg::REG_SWITCH_CONTROL: rdata_d = ctl_q;
              tsimm_pkg::REG_INTERFACE_MODE: rdata_d = ims_q;
              tsimm_pkg::REG_FRAME_ALIGN:    rdata_d = frame_align_in;
              tsimm_pkg::REG_FRAME_OFFSET:   rdata_d = for_q;
              default:                       rdata_d = 16'h0000;
            endcase
          end
          // a software write to interface mode wins over the hardware clear of go
          if (reg_wr) begin
            case (mp_addr[6:0])
              tsimm_pkg::REG_SWITCH_CONTROL:
                ctl_d = mp_data_in & tsimm_pkg::CTL_WMASK;
              tsimm_pkg::REG_INTERFACE_MODE:
                ims_d = mp_data_in & tsimm_pkg::IMS_WMASK;
              tsimm_pkg::REG_FRAME_OFFSET:
                for_d = mp_data_in;
              default: ;
            endcase
          end
        end
      end
      tsimm_pkg::ST_ACK: begin
        state_d = tsimm_pkg::ST_HOLD;
      end
      tsimm_pkg::ST_HOLD: begin
        if (!req) begin
          state_d = tsimm_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = tsimm_pkg::ST_IDLE;
      end
    endcase
  end

  // microport and register flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= tsimm_pkg::ST_IDLE;
      ctl_q      <= tsimm_pkg::CTL_RESET;
      ims_q      <= tsimm_pkg::IMS_RESET;
      for_q      <= tsimm_pkg::FOR_RESET;
      rdata_q    <= 16'h0000;
      rd_q       <= 1'h0;
      fill_idx_q <= 7'h00;
    end else begin
      state_q    <= state_d;
      ctl_q      <= ctl_d;
      ims_q      <= ims_d;
      for_q      <= for_d;
      rdata_q    <= rdata_d;
      rd_q       <= rd_d;
      fill_idx_q <= fill_idx_d;
    end
  end

  // handshake outputs
  assign mp_dta_n         = !(state_q == tsimm_pkg::ST_ACK);
  assign mp_data_oe       = (state_q == tsimm_pkg::ST_ACK) && rd_q;
  assign mp_data_out      = rdata_q;
  assign frame_offset_out = for_q;
  assign frame_eval_start = ims_q[tsimm_pkg::IMS_EVAL_BIT];
  assign tx_drivers_en    = drv_q;

  // transmit slot assembly
  assign src_slot = '{stream:  cm_tx.source_stream_field,
                      channel: cm_tx.source_channel_field};
  assign tx_byte  = cm_tx.processor_mode_bit ? cm_tx[7:0] : dm_src;
  assign lb_we    = tx_valid && cm_tx.channel_loopback;

  always_comb begin
    drv_d = global_drive_pin || output_standby_bit;
    txv_d = tx_valid;
    tx_d  = tx_q;
    if (tx_valid) begin
      tx_d.data             = tx_byte;
      tx_d.drive            = cm_tx.output_enable
                              && (global_drive_pin || output_standby_bit);
      tx_d.delay_const      = cm_tx.delay_const;
      tx_d.channel_loopback = cm_tx.channel_loopback;
      tx_d.delay_slots      = tsimm_pkg::delay_slots(
                                cm_tx.source_channel_field,
                                tx_slot.channel,
                                cm_tx.delay_const);
    end
  end

  // transmit flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drv_q <= 1'h0;
      txv_q <= 1'h0;
      tx_q  <= '0;
    end else begin
      drv_q <= drv_d;
      txv_q <= txv_d;
      tx_q  <= tx_d;
    end
  end

  assign tx_out_valid = txv_q;
  assign tx_out       = tx_q;

  // memories
  tsimm_conn_mem u_conn_mem (
    .clk         (clk),
    .wr_en       (cm_we),
    .wr_all      (cm_all),
    .wr_slot     (cm_wslot),
    .wr_word     (cm_wword),
    .rd_tx_slot  (tx_slot),
    .rd_tx_word  (cm_tx),
    .rd_rx_slot  (rx_slot),
    .rd_rx_word  (cm_rx),
    .rd_cpu_slot (cpu_slot),
    .rd_cpu_word (cm_cpu)
  );

  // looped channels take the transmit byte instead of the receive byte
  tsimm_data_mem u_data_mem (
    .clk         (clk),
    .rx_we       (rx_valid && !cm_rx.channel_loopback),
    .rx_slot     (rx_slot),
    .rx_data     (rx_data),
    .lb_we       (lb_we),
    .lb_slot     (tx_slot),
    .lb_data     (tx_byte),
    .rd_src_slot (src_slot),
    .rd_src_data (dm_src),
    .rd_cpu_slot (cpu_slot),
    .rd_cpu_data (dm_cpu)
  );

  // checks
  chk_reg_decode: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && mp_rw && mp_addr == 8'h00)
      |=> mp_data_out == $past(ctl_q) ##0 !mp_dta_n ##1 mp_dta_n)
    else $error("control register read mismatch");

  chk_unmapped_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && mp_rw && !mp_addr[7] && mp_addr[6:0] > 7'h03)
      |=> mp_data_out == 16'h0000 && mp_data_oe)
    else $error("unmapped register read not zero");

  chk_dm_read_sel: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && mp_rw && mp_addr[7] && ctl_q[tsimm_pkg::CTL_MEMSEL_BIT])
      |=> mp_data_out[15:8] == 8'h00 && mp_data_out[7:0] == $past(dm_cpu))
    else $error("data memory read wrong");

  chk_fill_done: assert property (
    @(posedge clk) disable iff (!rst_n)
    (fill_step && fill_idx_q == 7'h7F && !reg_wr)
      |=> !ims_q[tsimm_pkg::IMS_GO_BIT] && fill_idx_q == 7'h00)
    else $error("fill go not cleared at end");

  chk_fill_allow: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ctl_q[tsimm_pkg::CTL_FILL_ALLOW_BIT] |-> !fill_step
      ##1 ($stable(fill_idx_q) || fill_idx_q == 7'h00))
    else $error("fill ran without allow");

  chk_drive_pin: assert property (
    @(posedge clk) disable iff (!rst_n)
    (global_drive_pin || output_standby_bit) |=> tx_drivers_en)
    else $error("drivers not enabled");

  chk_standby_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!global_drive_pin && !output_standby_bit) |=> !tx_drivers_en)
    else $error("drivers enabled in standby");

  chk_slot_drive: assert property (
    @(posedge clk) disable iff (!rst_n)
    (tx_valid && !cm_tx.output_enable) |=> tx_out_valid && !tx_out.drive)
    else $error("disabled channel driven");

  chk_pmode_byte: assert property (
    @(posedge clk) disable iff (!rst_n)
    (tx_valid && cm_tx.processor_mode_bit)
      |=> tx_out.data == $past(cm_tx[7:0]))
    else $error("processor mode byte wrong");

  chk_const_delay: assert property (
    @(posedge clk) disable iff (!rst_n)
    (tx_valid && cm_tx.delay_const && tx_slot.channel == 7'h00
      && cm_tx.source_channel_field == 7'h00)
      |=> tx_out.delay_slots == 9'h100)
    else $error("constant delay figure wrong");

endmodule : tsimm_switch

/* File: tsimm_switch_test.sv */
`timescale 1ns/1ps
module tsimm_switch_test;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [15:0] d;
  } tsimm_row_type;
  // register rows: write, or read with expected value
  localparam tsimm_row_type ROWS [15] = '{
    '{1'b0, 8'h00, 16'h0000}, '{1'b0, 8'h01, 16'h0000},
    '{1'b0, 8'h03, 16'h0000}, '{1'b1, 8'h01, 16'h0004},
    '{1'b0, 8'h01, 16'h0004}, '{1'b1, 8'h00, 16'hFFFF},
    '{1'b0, 8'h00, 16'h0033}, '{1'b1, 8'h00, 16'h0000},
    '{1'b1, 8'h03, 16'hA5C3}, '{1'b0, 8'h03, 16'hA5C3},
    '{1'b1, 8'h03, 16'h0000}, '{1'b1, 8'h02, 16'h1234},
    '{1'b0, 8'h02, 16'h5A5A}, '{1'b1, 8'h05, 16'hFFFF},
    '{1'b0, 8'h05, 16'h0000}};
  localparam int DN [7] = '{10, 5, 5, 5, 5, 0, 0};
  localparam int DM [7] = '{5, 5, 7, 8, 8, 127, 0};
  localparam int DC [7] = '{0, 0, 0, 0, 1, 1, 1};
  logic                      clk, rst_n, req, rw, done, gdp;
  logic                      mp_cs_n, mp_ds, mp_rw, mp_dta_n;
  logic [7:0]                addr, mp_addr, rx_data;
  logic [15:0]               wdata, rdata, mp_data_in, mp_data_out, fofs;
  logic                      rx_valid, tx_valid, tx_out_valid;
  logic                      tx_drivers_en, frame_eval_start;
  tsimm_pkg::tsimm_slot_type rx_slot, tx_slot;
  tsimm_pkg::tsimm_tx_type   tx_out;
  int                        error_cnt, n_checks, cyc;

  tsimm_host tsimm_host_inst (
    .clk(clk), .req(req), .rw(rw), .addr(addr), .wdata(wdata),
    .done(done), .rdata(rdata), .mp_cs_n(mp_cs_n), .mp_ds(mp_ds),
    .mp_rw(mp_rw), .mp_addr(mp_addr), .mp_data_in(mp_data_in),
    .mp_data_out(mp_data_out), .mp_dta_n(mp_dta_n));
  tsimm_switch tsimm_switch_inst (
    .clk(clk), .rst_n(rst_n), .mp_cs_n(mp_cs_n), .mp_ds(mp_ds),
    .mp_rw(mp_rw), .mp_addr(mp_addr), .mp_data_in(mp_data_in),
    .mp_data_out(mp_data_out), .mp_data_oe(), .mp_dta_n(mp_dta_n),
    .global_drive_pin(gdp), .frame_align_in(16'h5A5A),
    .frame_offset_out(fofs), .frame_eval_start(frame_eval_start),
    .rx_valid(rx_valid), .rx_slot(rx_slot), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_slot(tx_slot),
    .tx_out_valid(tx_out_valid), .tx_out(tx_out),
    .tx_drivers_en(tx_drivers_en));

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t word %h exp %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_tx(input tsimm_pkg::tsimm_tx_type g,
                        input tsimm_pkg::tsimm_tx_type e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t slot %h exp %h", $time, g, e);
    end
  endtask : chk_tx
  // one microport cycle through the host model
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk);
    req   <= 1'b1;
    rw    <= ~w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 20);
    if (n == 20) chk_word(16'hDEAD, 16'h0000);
    q = rdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    xfer(1'b0, a, 16'h0000, q);
    chk_word(q, e);
  endtask : rd
  task automatic send_tx(input logic [6:0] ch,
                         input tsimm_pkg::tsimm_tx_type e);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_slot  <= '{2'h0, ch};
    @(posedge clk);
    tx_valid <= 1'b0;
    tx_slot  <= '{2'h3, ~ch};
    @(negedge clk);
    chk_tx(tx_out, e);
    chk_word({15'h0, tx_out_valid}, 16'h0001);
  endtask : send_tx
  task automatic rx_put(input tsimm_pkg::tsimm_slot_type s,
                        input logic [7:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_slot  <= s;
    rx_data  <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~d;
  endtask : rx_put
  // expected throughput delay
  function automatic logic [8:0] dly(int n, int m, logic c);
    if (c) return 9'(256 - n + m);
    if (m < n) return 9'(128 - n + m);
    if (m <= n + 2) return 9'(m - n + 128);
    return 9'(m - n);
  endfunction : dly

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin : main
    logic [15:0] w, q;
    int          n;
    {rst_n, req, rw, gdp, rx_valid, tx_valid} = 6'h08;
    {addr, wdata, rx_data, rx_slot, tx_slot} = '0;
    {error_cnt, n_checks, cyc} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // drive pin stays low while paths are set up
    foreach (ROWS[i]) begin
      if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
      else rd(ROWS[i].a, ROWS[i].d);
      if (ROWS[i].w && ROWS[i].a == 8'h03) chk_word(fofs, ROWS[i].d);
    end
    chk_word({15'h0, frame_eval_start}, 16'h0001);
    $display("register test done");
    for (int i = 0; i < 7; i++) begin
      w = 16'h6000 | (16'(DC[i]) << 12) | 16'(DN[i]);
      wr(8'h80 | 8'(DM[i]), w);
      send_tx(7'(DM[i]), {w[7:0], 1'b0, w[12], 1'b0,
              dly(DN[i], DM[i], w[12])});
    end
    $display("delay test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      gdp <= i[1];
      wr(8'h01, {14'h0, i[0], 1'b0});
      send_tx(7'h7F, {8'h00, i[1] | i[0], 2'h2, 9'h17F});
      chk_word({15'h0, tx_drivers_en}, {15'h0, i[1] | i[0]});
    end
    wr(8'hFE, 16'h4000);
    send_tx(7'h7E, {8'h00, 3'h0, 9'h07E});
    $display("drive test done");
    // receive slot word starts undefined, clear its loopback first
    wr(8'h00, 16'h0001);
    wr(8'h89, 16'h0000);
    wr(8'h00, 16'h0000);
    rx_put('{2'h1, 7'h09}, 8'h3C);
    wr(8'h94, 16'h2089);
    send_tx(7'h14, {8'h3C, 3'h4, 9'h00B});
    wr(8'h00, 16'h0011);
    rd(8'h89, 16'h003C);
    wr(8'h89, 16'h1234);
    wr(8'h00, 16'h0001);
    rd(8'h89, 16'h1234);
    wr(8'h00, 16'h0000);
    wr(8'h9E, 16'h4855);
    send_tx(7'h1E, {8'h55, 3'h1, 9'h049});
    rx_put('{2'h0, 7'h1E}, 8'hAA);
    wr(8'h00, 16'h0010);
    rd(8'h9E, 16'h0055);
    $display("switching test done");
    wr(8'h00, 16'h0000);
    wr(8'h01, 16'h02A1);
    repeat (140) @(posedge clk);
    rd(8'h01, 16'h02A1);
    wr(8'h00, 16'h0020);
    n = 0;
    do begin
      xfer(1'b0, 8'h01, 16'h0000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    chk_word(q, 16'h02A0);
    wr(8'h00, 16'h0023);
    rd(8'hFF, 16'hA800);
    $display("block fill test done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'h0000);
    $display("reset test done");
    give_verdict();
  end
endmodule : tsimm_switch_test
